// ---- hw/twc_ctrl.sv ----
/*
 Two-wire transfer sequencer for master transmit: control, status,
 data and mode registers on an Avalon-MM slave, with a bit engine
 on the link clock. Assumes open-drain pads resolve SCL and SDA
 from the enables, and rst synchronous to clk.
*/
// Overview of operation
// RQ1 - Four modes known; master modes tracked here
// RQ2 - Software alone decides which modes are allowed
// RQ3 - Direction bit: high read, low write
// RQ4 - Acknowledge low, not-acknowledge high on SDA
// RQ5 - One eight-bit byte then acknowledge slot
// RQ6 - Address sent: set flag, post status
// RQ7 - Data sent: set flag, post outcome status
// RQ8 - Software masks status with 0xF8 before compare
// RQ9 - Software loads data, then clears flag enabled
// RQ10 - Transfer suspended while flag is set
// RQ11 - Software reads status whenever flag set
// RQ12 - Writing one clears flag; none starts otherwise
// RQ13 - SCL held low while flag set
// RQ14 - Data write without flag: dropped, collision set
// RQ15 - Flag-clear, enable, stop without start sends STOP
// RQ16 - Interrupt request while flag and enable set
`timescale 1ns/1ps
`default_nettype none
`include "twc_params.svh"

module twc_ctrl
	import twc_pkg::*;
#(
	parameter int AW = 4
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic link_clk,
	input wire logic [AW-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic irq,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe
);

	if (AW < 4) begin : g_aw_check
		$error("twc_ctrl: AW must be at least 4");
	end

	logic flag_r;
	logic acken_r;
	logic sta_r;
	logic sto_r;
	logic wc_r;
	logic en_r;
	logic ie_r;
	logic flag_nxt;
	logic [1:0] presc_r;
	logic [7:0] code_r;
	logic [7:0] data_r;
	twc_mode_t mode_r;
	logic owned_r;
	logic addr_next_r;
	logic busy_r;
	twc_cmd_t cmd_r;
	logic req_tgl_r;
	logic done_tgl;
	logic link_nack;
	logic done_s1;
	logic done_s2;
	logic done_seen_r;
	logic done_ev;
	logic acc;
	logic wr_ctrl;
	logic wr_status;
	logic wr_data;
	logic issue;
	logic flag_clear;
	logic [3:0] reg_addr;
	twc_op_t op_sel;

	// Register decode on the byte address
	assign reg_addr = address[3:0];
	assign acc = (read || write) && !waitrequest;
	assign wr_ctrl = acc && write && (reg_addr == `TWC_OFF_CTRL);
	assign wr_status = acc && write && (reg_addr == `TWC_OFF_STATUS);
	assign wr_data = acc && write && (reg_addr == `TWC_OFF_DATA);
	assign flag_clear = wr_ctrl && writedata[`TWC_CB_FLAG]; // [RQ12]
	assign done_ev = done_s2 != done_seen_r;

	// An operation starts only while the flag is being cleared [RQ12] [RQ9]
	assign issue = flag_clear && writedata[`TWC_CB_EN] && !busy_r &&
		(writedata[`TWC_CB_START] || writedata[`TWC_CB_STOP] || owned_r);

	// Operation picked from the start and stop bits
	always_comb begin
		if (writedata[`TWC_CB_START] && writedata[`TWC_CB_STOP]) begin
			op_sel = TWC_OP_STOP_START;
		end else if (writedata[`TWC_CB_STOP]) begin
			op_sel = TWC_OP_STOP; // [RQ15]
		end else if (writedata[`TWC_CB_START]) begin
			op_sel = TWC_OP_START;
		end else begin
			op_sel = TWC_OP_BYTE;
		end
	end

	// Flag set by a finished step wins over a clear in the same cycle
	always_comb begin
		flag_nxt = flag_r;
		if (flag_clear) begin
			flag_nxt = 1'b0;
		end
		if (done_ev && cmd_r.op != TWC_OP_STOP) begin
			flag_nxt = 1'b1; // [RQ6] [RQ7]
		end
	end

	// Bus slave handshake: one wait cycle, answer on the next
	always_ff @(posedge clk) begin
		if (rst) begin
			waitrequest <= 1'b1;
		end else if ((read || write) && waitrequest) begin
			waitrequest <= 1'b0;
		end else begin
			waitrequest <= 1'b1;
		end
	end

	// Read data captured in the wait cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			readdata <= 32'h0000_0000;
		end else if (read && waitrequest) begin
			unique case (reg_addr)
				`TWC_OFF_CTRL: readdata <= {24'h00_0000, flag_r, acken_r, sta_r, sto_r,
					wc_r, en_r, 1'b0, ie_r};
				// Prescaler bits sit below the code for software to mask [RQ8] [RQ11]
				`TWC_OFF_STATUS: readdata <= {24'h00_0000,
					code_r[`TWC_SB_CODE_HI:`TWC_SB_CODE_LO], 1'b0, presc_r};
				`TWC_OFF_DATA: readdata <= {24'h00_0000, data_r};
				`TWC_OFF_MODE: readdata <= {29'h0000_0000, mode_r};
				default: readdata <= 32'h0000_0000;
			endcase
		end
	end

	// Control register
	always_ff @(posedge clk) begin
		if (rst) begin
			flag_r <= 1'b0;
			acken_r <= 1'b0;
			sta_r <= 1'b0;
			sto_r <= 1'b0;
			en_r <= 1'b0;
			ie_r <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
			if (wr_ctrl) begin
				acken_r <= writedata[`TWC_CB_ACKEN];
				sta_r <= writedata[`TWC_CB_START];
				en_r <= writedata[`TWC_CB_EN];
				ie_r <= writedata[`TWC_CB_IE];
			end
			// Stop bit reads back until its STOP has gone out
			if (done_ev && (cmd_r.op == TWC_OP_STOP || cmd_r.op == TWC_OP_STOP_START)) begin
				sto_r <= 1'b0;
			end else if (wr_ctrl) begin
				sto_r <= writedata[`TWC_CB_STOP];
			end
		end
	end

	// Data register and write collision
	always_ff @(posedge clk) begin
		if (rst) begin
			data_r <= `TWC_DATA_RST;
			wc_r <= 1'b0;
		end else if (wr_data) begin
			if (flag_r) begin
				data_r <= writedata[7:0];
				wc_r <= 1'b0;
			end else begin
				wc_r <= 1'b1; // [RQ14]
			end
		end
	end

	// Prescaler bits: stored for software, no effect
	always_ff @(posedge clk) begin
		if (rst) begin
			presc_r <= `TWC_PRE_RST;
		end else if (wr_status) begin
			presc_r <= writedata[`TWC_SB_PRE_HI:`TWC_SB_PRE_LO];
		end
	end

	// Command hand-off to the link domain; cmd_r stays put until done
	always_ff @(posedge clk) begin
		if (rst) begin
			cmd_r <= '{op: TWC_OP_START, data: `TWC_DATA_RST};
			req_tgl_r <= 1'b0;
			busy_r <= 1'b0;
		end else if (issue) begin
			cmd_r <= '{op: op_sel, data: data_r};
			req_tgl_r <= ~req_tgl_r;
			busy_r <= 1'b1;
		end else if (done_ev) begin
			busy_r <= 1'b0;
		end
	end

	// Done toggle synchroniser from the link domain
	always_ff @(posedge clk) begin
		done_s1 <= done_tgl;
		done_s2 <= done_s1;
	end

	// One done event per toggle
	always_ff @(posedge clk) begin
		if (rst) begin
			done_seen_r <= 1'b0;
		end else begin
			done_seen_r <= done_s2;
		end
	end

	// Status code, bus ownership and mode after each finished step
	always_ff @(posedge clk) begin
		if (rst) begin
			code_r <= `TWC_ST_IDLE;
			owned_r <= 1'b0;
			addr_next_r <= 1'b0;
			mode_r <= TWC_MODE_NONE;
		end else if (done_ev) begin
			unique case (cmd_r.op)
				TWC_OP_START, TWC_OP_STOP_START: begin
					code_r <= (owned_r && cmd_r.op == TWC_OP_START) ?
						`TWC_ST_REP_START : `TWC_ST_START;
					owned_r <= 1'b1;
					addr_next_r <= 1'b1;
				end
				TWC_OP_BYTE: begin
					addr_next_r <= 1'b0;
					if (addr_next_r) begin
						// Mode follows the direction bit; no mode is refused [RQ1] [RQ2]
						if (cmd_r.data[0]) begin
							code_r <= link_nack ? `TWC_ST_AR_NACK : `TWC_ST_AR_ACK;
							mode_r <= TWC_MODE_MASTER_RECEIVE;
						end else begin
							code_r <= link_nack ? `TWC_ST_AW_NACK : `TWC_ST_AW_ACK; // [RQ6]
							mode_r <= TWC_MODE_MASTER_TRANSMIT;
						end
					end else begin
						code_r <= link_nack ? `TWC_ST_DW_NACK : `TWC_ST_DW_ACK; // [RQ7]
					end
				end
				TWC_OP_STOP: begin
					code_r <= `TWC_ST_IDLE;
					owned_r <= 1'b0;
					mode_r <= TWC_MODE_NONE;
				end
			endcase
		end
	end

	// Interrupt request one cycle behind the flag
	always_ff @(posedge clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= flag_r && ie_r; // [RQ16]
		end
	end

	// Open-drain pads only ever pull low
	always_ff @(posedge clk) begin
		scl_out <= 1'b0;
		sda_out <= 1'b0;
	end

	// Link engine idles with SCL low after a START or byte step until the next command; after STOP both lines are released [RQ10] [RQ13]
	twc_link u_link (
		.link_clk(link_clk),
		.rst(rst),
		.cmd(cmd_r),
		.req_tgl(req_tgl_r),
		.done_tgl(done_tgl),
		.nack(link_nack),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.scl_oe(scl_oe),
		.sda_oe(sda_oe)
	);

endmodule
`default_nettype wire

// ---- hw/twc_link.sv ----
/*
 Bit engine of the two-wire sequencer on the link clock: START, byte,
 acknowledge slot and STOP, four link clocks per bit.
 Assumes cmd is stable whenever req_tgl has toggled and done_tgl not yet.
*/
`timescale 1ns/1ps
`default_nettype none
`include "twc_params.svh"

module twc_link
	import twc_pkg::*;
(
	input wire logic link_clk,
	input wire logic rst,
	input wire twc_cmd_t cmd,
	input wire logic req_tgl,
	output logic done_tgl,
	output logic nack,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_oe,
	output logic sda_oe
);

	logic rst_s1, lrst;
	logic req_s1, req_s2, req_seen_r;
	logic scl_s1, scl_s, sda_s1, sda_s;
	twc_lstate_t state_r;
	twc_op_t op_r;
	logic [1:0] ph_r;
	logic [2:0] bit_r;
	logic [7:0] sh_r;
	logic pending;

	// Reset and input synchronisers
	always_ff @(posedge link_clk) begin
		rst_s1 <= rst;
		lrst <= rst_s1;
		req_s1 <= req_tgl;
		req_s2 <= req_s1;
		scl_s1 <= scl_in;
		scl_s <= scl_s1;
		sda_s1 <= sda_in;
		sda_s <= sda_s1;
	end

	assign pending = req_s2 != req_seen_r;

	always_ff @(posedge link_clk) begin
		if (lrst) begin
			state_r <= TWC_LS_IDLE;
			op_r <= TWC_OP_START;
			ph_r <= `TWC_PH_0;
			bit_r <= `TWC_BIT_FIRST;
			sh_r <= `TWC_DATA_RST;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			nack <= 1'b0;
			done_tgl <= 1'b0;
			req_seen_r <= 1'b0;
		end else begin
			unique case (state_r)
				TWC_LS_IDLE: begin
					// Lines stay as left: SCL low after a START or byte step stretches the bus [RQ13]
					if (pending) begin
						req_seen_r <= req_s2;
						op_r <= cmd.op;
						sh_r <= cmd.data;
						ph_r <= `TWC_PH_0;
						bit_r <= `TWC_BIT_FIRST;
						unique case (cmd.op)
							TWC_OP_START: state_r <= TWC_LS_START;
							TWC_OP_BYTE: state_r <= TWC_LS_BITS;
							TWC_OP_STOP, TWC_OP_STOP_START: state_r <= TWC_LS_STOP;
						endcase
					end
				end
				TWC_LS_START: begin
					unique case (ph_r)
						`TWC_PH_0: begin
							sda_oe <= 1'b0;
							ph_r <= `TWC_PH_1;
						end
						`TWC_PH_1: begin
							scl_oe <= 1'b0;
							ph_r <= `TWC_PH_2;
						end
						`TWC_PH_2: begin
							// Wait for a free bus, then pull SDA low with SCL high
							if (scl_s && sda_s) begin
								sda_oe <= 1'b1;
								ph_r <= `TWC_PH_LAST;
							end
						end
						`TWC_PH_LAST: begin
							scl_oe <= 1'b1;
							nack <= 1'b0;
							done_tgl <= ~done_tgl;
							state_r <= TWC_LS_IDLE;
						end
					endcase
				end
				TWC_LS_BITS: begin
					unique case (ph_r)
						`TWC_PH_0: sda_oe <= ~sh_r[7]; // [RQ3]
						`TWC_PH_1: scl_oe <= 1'b0;
						`TWC_PH_2: scl_oe <= 1'b0;
						`TWC_PH_LAST: begin
							scl_oe <= 1'b1;
							sh_r <= {sh_r[6:0], 1'b0};
							bit_r <= bit_r + 3'h1;
							// Exactly eight data bits, then the acknowledge slot [RQ5]
							if (bit_r == `TWC_BIT_LAST) begin
								state_r <= TWC_LS_ACK;
							end
						end
					endcase
					ph_r <= ph_r + 2'h1;
				end
				TWC_LS_ACK: begin
					unique case (ph_r)
						`TWC_PH_0: sda_oe <= 1'b0;
						`TWC_PH_1: scl_oe <= 1'b0;
						`TWC_PH_2: scl_oe <= 1'b0;
						`TWC_PH_LAST: begin
							// Low SDA is acknowledge, high is not-acknowledge [RQ4]
							nack <= sda_s;
							scl_oe <= 1'b1;
							done_tgl <= ~done_tgl;
							state_r <= TWC_LS_IDLE;
						end
					endcase
					ph_r <= ph_r + 2'h1;
				end
				TWC_LS_STOP: begin
					unique case (ph_r)
						`TWC_PH_0: sda_oe <= 1'b1;
						`TWC_PH_1: scl_oe <= 1'b0;
						`TWC_PH_2: sda_oe <= 1'b0; // [RQ15]
						`TWC_PH_LAST: begin
							nack <= 1'b0;
							if (op_r == TWC_OP_STOP_START) begin
								state_r <= TWC_LS_START;
							end else begin
								done_tgl <= ~done_tgl;
								state_r <= TWC_LS_IDLE;
							end
						end
					endcase
					ph_r <= ph_r + 2'h1;
				end
				default: state_r <= TWC_LS_IDLE;
			endcase
		end
	end

endmodule
`default_nettype wire

// ---- hw/twc_params.svh ----
/*
 Constants of the two-wire transmit sequencer: register offsets,
 field positions, reset values, status codes and bit timing.
 Assumes byte addresses on a 32-bit Avalon-MM slave port.
*/
`ifndef TWC_PARAMS_SVH
`define TWC_PARAMS_SVH

`define TWC_OFF_CTRL 4'h0
`define TWC_OFF_STATUS 4'h4
`define TWC_OFF_DATA 4'h8
`define TWC_OFF_MODE 4'hC

`define TWC_CB_FLAG 7
`define TWC_CB_ACKEN 6
`define TWC_CB_START 5
`define TWC_CB_STOP 4
`define TWC_CB_WC 3
`define TWC_CB_EN 2
`define TWC_CB_IE 0

`define TWC_SB_CODE_HI 7
`define TWC_SB_CODE_LO 3
`define TWC_SB_PRE_HI 1
`define TWC_SB_PRE_LO 0

`define TWC_DATA_RST 8'hFF
`define TWC_PRE_RST 2'h0

`define TWC_ST_START 8'h08
`define TWC_ST_REP_START 8'h10
`define TWC_ST_AW_ACK 8'h18
`define TWC_ST_AW_NACK 8'h20
`define TWC_ST_DW_ACK 8'h28
`define TWC_ST_DW_NACK 8'h30
`define TWC_ST_AR_ACK 8'h40
`define TWC_ST_AR_NACK 8'h48
`define TWC_ST_IDLE 8'hF8

`define TWC_PH_0 2'h0
`define TWC_PH_1 2'h1
`define TWC_PH_2 2'h2
`define TWC_PH_LAST 2'h3
`define TWC_BIT_FIRST 3'h0
`define TWC_BIT_LAST 3'h7

`endif

// ---- hw/twc_pkg.sv ----
/*
 Types of the two-wire transmit sequencer: link operations,
 the command carried to the link domain, link states and modes.
 Assumes twc_params.svh for numeric constants.
*/
package twc_pkg;

	typedef enum logic [1:0] {
		TWC_OP_START = 2'h0,
		TWC_OP_BYTE = 2'h1,
		TWC_OP_STOP = 2'h2,
		TWC_OP_STOP_START = 2'h3
	} twc_op_t;

	typedef struct packed {
		twc_op_t op;
		logic [7:0] data;
	} twc_cmd_t;

	typedef enum logic [4:0] {
		TWC_LS_IDLE = 5'h01,
		TWC_LS_START = 5'h02,
		TWC_LS_BITS = 5'h04,
		TWC_LS_ACK = 5'h08,
		TWC_LS_STOP = 5'h10
	} twc_lstate_t;

	typedef enum logic [2:0] {
		TWC_MODE_NONE = 3'h0,
		TWC_MODE_MASTER_TRANSMIT = 3'h1,
		TWC_MODE_MASTER_RECEIVE = 3'h2,
		TWC_MODE_SLAVE_TRANSMIT = 3'h3,
		TWC_MODE_SLAVE_RECEIVE = 3'h4
	} twc_mode_t;

endpackage

// ---- verification/twc_ctrl_sva.sv ----
/*
 Checker of bus answers, interrupt and line hold of twc_ctrl.
 Assumes link clock eight times slower than clk.
*/
`timescale 1ns/1ps
`default_nettype none
module twc_ctrl_sva #(parameter int AW = 4) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [AW-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic irq,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_out,
	input wire logic sda_oe
);
	logic ie_r;
	logic [6:0] hi_r;
	logic [6:0] qt_r;
	wire ctl_w = write && !waitrequest && address[3:0] == 4'h0;
	always_ff @(posedge clk) ie_r <= rst ? 1'b0 : (ctl_w ? writedata[0] : ie_r);
	// Long SCL low with no write means a suspended step
	always_ff @(posedge clk) hi_r <= (rst || !scl_oe) ? 7'h00 : hi_r + {6'h00, hi_r != 7'h7F};
	always_ff @(posedge clk) qt_r <= (rst || write) ? 7'h00 : qt_r + {6'h00, qt_r != 7'h7F};
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("no bus answer");
	a_idle_wait: assert property (!read && !write |=> waitrequest)
		else $error("answer without request");
	a_open_drain: assert property (scl_out == 1'b0 && sda_out == 1'b0)
		else $error("line driven high");
	a_scl_held: assert property (hi_r > 7'h28 && qt_r > 7'h3C |=> scl_oe)
		else $error("suspended clock released");
	a_irq_masked: assert property (!ie_r && !$past(ie_r) |-> !irq)
		else $error("irq while disabled");
	a_irq_clear: assert property (ctl_w && writedata[7] |-> ##2 !irq)
		else $error("irq after clear");
	a_stop_frees: assert property (ctl_w && writedata[7] && !writedata[5] && writedata[4]
		&& writedata[2] |-> ##[1:300] (!scl_oe && !sda_oe))
		else $error("stop left lines low");
	a_read_top: assert property (read && !waitrequest |-> readdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	c_irq: cover property ($rose(irq));
	c_hold: cover property (hi_r > 7'h28);
	c_stop: cover property (ctl_w && writedata[4]);
endmodule
bind twc_ctrl twc_ctrl_sva #(.AW(AW)) u_twc_ctrl_sva (.clk(clk), .rst(rst), .address(address),
	.read(read), .write(write), .writedata(writedata), .readdata(readdata),
	.waitrequest(waitrequest), .irq(irq), .scl_out(scl_out), .scl_oe(scl_oe),
	.sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire

// ---- verification/twc_ctrl_test.sv ----
/*
 Testbench of twc_ctrl: master transmit steps over Avalon-MM.
 Assumes twc_slave_model on the lines and pull-ups on both.
*/
`timescale 1ns/1ps
`default_nettype none
module twc_ctrl_test;
	logic clk = 0, rst = 1, link_clk = 0, read = 0, write = 0, nack_mode = 0;
	logic [3:0] address = 4'h0;
	logic [31:0] writedata = 32'h0, readdata, q;
	logic waitrequest, irq, scl_oe, sda_oe, scl_out, sda_out, s_oe;
	logic [7:0] rx_byte;
	int err_total = 0, cmp_count = 0, cyc = 0;
	wire scl = !scl_oe;
	wire sda = !(sda_oe || s_oe);
	always #10 clk = ~clk;
	initial begin
		#7;
		forever #80 link_clk = ~link_clk;
	end
	twc_ctrl #(.AW(4)) u_twc_ctrl (.clk(clk), .rst(rst), .link_clk(link_clk),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .irq(irq), .scl_in(scl),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
	twc_slave_model u_twc_slave_model (.scl(scl), .sda(sda), .nack_mode(nack_mode),
		.sda_oe(s_oe), .rx_byte(rx_byte));
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			err_total++;
			end_of_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Request held until waitrequest is sampled low
	task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
		read <= rd;
		write <= !rd;
		address <= a;
		writedata <= d;
		do @(posedge clk); while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		bus(1'b1, a, 32'h0);
		chk(q, e);
	endtask
	task automatic wait_ctl(input int b, input logic v);
		do bus(1'b1, 4'h0, 32'h0); while (q[b] !== v);
	endtask
	// A START step has no data byte, so DATA is left alone
	task automatic step(input logic [7:0] d, input logic [7:0] c, input logic [7:0] st);
		if (!c[5]) bus(1'b0, 4'h8, {24'h0, d});
		bus(1'b0, 4'h0, {24'h0, c});
		wait_ctl(7, 1'b1);
		bus(1'b1, 4'h4, 32'h0);
		chk(q & 32'hF8, {24'h0, st});
	endtask
	task automatic t_reset();
		rd(4'h0, 32'h0);
		rd(4'h4, 32'hF8);
		rd(4'h8, 32'hFF);
		rd(4'hC, 32'h0);
		rd(4'h2, 32'h0);
	endtask
	task automatic t_collide();
		bus(1'b0, 4'h8, 32'h55);
		rd(4'h0, 32'h08);
		rd(4'h8, 32'hFF);
	endtask
	task automatic t_start();
		step(8'h00, 8'hA5, 8'h08);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		bus(1'b0, 4'h0, 32'h05);
		repeat (150) @(posedge clk);
		chk({31'h0, scl_oe}, 32'h1);
		rd(4'h0, 32'h8D);
		rd(4'h4, 32'h08);
	endtask
	task automatic t_bytes();
		step(8'hA4, 8'h85, 8'h18);
		chk({24'h0, rx_byte}, 32'hA4);
		rd(4'h0, 32'h85);
		rd(4'hC, 32'h1);
		bus(1'b0, 4'h4, 32'h3);
		step(8'h3C, 8'h85, 8'h28);
		chk({30'h0, q[1:0]}, 32'h3);
		chk({24'h0, rx_byte}, 32'h3C);
		nack_mode <= 1'b1;
		step(8'hC3, 8'h84, 8'h30);
		nack_mode <= 1'b0;
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
	endtask
	task automatic t_repeat();
		step(8'h00, 8'hA4, 8'h10);
		step(8'hA5, 8'h84, 8'h40);
		rd(4'hC, 32'h2);
	endtask
	task automatic t_stop();
		bus(1'b0, 4'h0, 32'h94);
		wait_ctl(4, 1'b0);
		repeat (20) @(posedge clk);
		rd(4'h0, 32'h04);
		rd(4'h4, 32'hFB);
		chk({30'h0, scl_oe, sda_oe}, 32'h0);
	endtask
	task automatic t_refuse();
		bus(1'b0, 4'h0, 32'h84);
		bus(1'b0, 4'h0, 32'h80);
		repeat (400) @(posedge clk);
		rd(4'h0, 32'h00);
		chk({24'h0, rx_byte}, 32'hA5);
		chk({30'h0, scl_oe, sda_oe}, 32'h0);
	endtask
	initial begin
		repeat (25) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_collide();
		t_start();
		t_bytes();
		t_repeat();
		t_stop();
		t_refuse();
		end_of_test();
	end
endmodule
`default_nettype wire

// ---- verification/twc_slave_model.sv ----
/*
 Slave on the two-wire bus: shifts in each byte, answers the slot.
 Assumes the bench resolves both open-drain lines with pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none
module twc_slave_model (
	input wire logic scl,
	input wire logic sda,
	input wire logic nack_mode,
	output logic sda_oe,
	output logic [7:0] rx_byte
);
	int n = 0;
	logic [7:0] sh = 8'h00;
	initial sda_oe = 1'b0;
	initial rx_byte = 8'h00;
	// START or STOP restarts the byte count
	always @(sda) if (scl === 1'b1) n = 0;
	always @(posedge scl) begin
		if (n < 8) sh = {sh[6:0], sda};
		n = n + 1;
		// Publish whole bytes only; START and STOP clock edges never reach it
		if (n == 8) rx_byte = sh;
	end
	always @(negedge scl) begin
		if (n == 8) sda_oe = !nack_mode;
		if (n == 9) begin
			sda_oe = 1'b0;
			n = 0;
		end
	end
endmodule
`default_nettype wire
